// [rtl/thm_params.svh]
// Constants for the terminal handshake block: modes, timing and counts
`ifndef THM_PARAMS_SVH
`define THM_PARAMS_SVH

`define THM_CLK_HZ 25000000
`define THM_TICK_MS 1
`define THM_CYC_PER_TICK ((`THM_CLK_HZ / 1000) * `THM_TICK_MS)

`define THM_MODE_ANSWER 4'hC
`define THM_MODE_HOTLINE 4'hD
`define THM_MODE_FORCED 4'hE
`define THM_MODE_CONT_HOT 4'hF

`define THM_RING_ON_MS 16'h07D0
`define THM_RING_OFF_MS 16'h0FA0
`define THM_DROP_MS 16'h00C8
`define THM_DTR_MIN_MS 16'h0064
`define THM_RETRY_MS 16'h9C40
`define THM_SHORT_BRK_CNT 2'h3

`endif

// [rtl/thm_pkg.sv]
// Types for the terminal handshake block
package thm_pkg;

    typedef enum logic [6:0] {
        THM_IDLE = 7'b0000001,
        THM_RING = 7'b0000010,
        THM_DIALING = 7'b0000100,
        THM_HOT_WAIT = 7'b0001000,
        THM_HOT_RETRY = 7'b0010000,
        THM_CONNECTED = 7'b0100000,
        THM_DROP = 7'b1000000
    } thm_state_t;

endpackage : thm_pkg

// [rtl/thm_tick.sv]
// Millisecond tick divider for the terminal handshake block
`timescale 1ns/1ps
`default_nettype none
module thm_tick #(
    parameter int CYCLES = 25000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic tick_o
);
    logic [31:0] count;

    // Single enable pulse, so all timers share one clock
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count <= 32'h00000000;
            tick_o <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count <= 32'h00000000;
            tick_o <= 1'b1;
        end else begin
            count <= count + 32'h00000001;
            tick_o <= 1'b0;
        end
    end
endmodule : thm_tick
`default_nettype wire

// [rtl/thm_top.sv]
// Terminal-facing control-lead handshake for terminal-access modes 12 to 15
`include "thm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module thm_top #(
    parameter int CYC_PER_TICK = `THM_CYC_PER_TICK
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic [3:0] MODE_I,
    input wire logic DTR_I,
    input wire logic CR_I,
    input wire logic BREAK_LONG_I,
    input wire logic BREAK_SHORT_I,
    input wire logic CMD_VALID_I,
    input wire logic [7:0] CMD_CHAR_I,
    input wire logic DM_CALL_IN_I,
    input wire logic DM_CLEAR_I,
    input wire logic DM_ANSWERED_I,
    input wire logic DM_FAIL_I,
    output logic DSR_O,
    output logic DCD_O,
    output logic CTS_O,
    output logic RI_O,
    output logic AUTOBAUD_O,
    output logic ECHO_VALID_O,
    output logic [7:0] ECHO_CHAR_O,
    output logic ANSWER_O,
    output logic HOTLINE_DIAL_O,
    output logic TERM_CLEAR_O,
    output logic CONNECTED_O
);
    thm_pkg::thm_state_t state;
    thm_pkg::thm_state_t next_state;
    logic tick;
    logic dtr_meta;
    logic dtr_sync;
    logic dtr_prev;
    logic [15:0] ms_cnt;
    logic [15:0] dtr_on_ms;
    logic [1:0] short_brk;
    logic mode_ans;
    logic dtr_eff;
    logic dtr_rise;
    logic dtr_fall_clear;
    logic brk_clear;
    logic ring_wrap;
    logic go_answer;
    logic go_dial;
    logic go_term_clear;

    thm_tick #(.CYCLES(CYC_PER_TICK)) u_tick (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .tick_o(tick)
    );

    // DTR comes from the terminal pin, so it is synchronised first
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            dtr_meta <= 1'b0;
            dtr_sync <= 1'b0;
            dtr_prev <= 1'b0;
        end else begin
            dtr_meta <= DTR_I;
            dtr_sync <= dtr_meta;
            dtr_prev <= dtr_sync;
        end
    end

    assign mode_ans = (MODE_I == `THM_MODE_ANSWER) || (MODE_I == `THM_MODE_FORCED);
    assign dtr_eff = (MODE_I == `THM_MODE_FORCED) ? 1'b1 : dtr_sync;
    assign dtr_rise = dtr_sync && !dtr_prev;

    // DTR on-time, saturating; a fall only clears after the minimum hold
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I || !dtr_sync) begin
            dtr_on_ms <= 16'h0000;
        end else if (tick && dtr_on_ms != 16'hFFFF) begin
            dtr_on_ms <= dtr_on_ms + 16'h0001;
        end
    end

    // Mode 14 never clears on DTR; other modes share the same rule
    assign dtr_fall_clear = (MODE_I != `THM_MODE_FORCED) && dtr_prev && !dtr_sync
        && (dtr_on_ms >= `THM_DTR_MIN_MS);

    // Short breaks count only within a connection
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I || state != thm_pkg::THM_CONNECTED) begin
            short_brk <= 2'h0;
        end else if (BREAK_SHORT_I) begin
            short_brk <= short_brk + 2'h1;
        end
    end

    assign brk_clear = BREAK_LONG_I || (BREAK_SHORT_I
        && short_brk == `THM_SHORT_BRK_CNT - 2'h1);

    // Cadence wrap only in ringing, else it would cut the 40 s retry timer short
    assign ring_wrap = (ms_cnt == `THM_RING_ON_MS + `THM_RING_OFF_MS - 16'h0001) && tick
        && state == thm_pkg::THM_RING;

    always_comb begin
        next_state = state;
        go_answer = 1'b0;
        go_dial = 1'b0;
        go_term_clear = 1'b0;
        unique case (state)
            thm_pkg::THM_IDLE: begin
                if (DM_CALL_IN_I && mode_ans) begin
                    if (dtr_eff) begin
                        next_state = thm_pkg::THM_CONNECTED;
                        go_answer = 1'b1;
                    end else begin
                        next_state = thm_pkg::THM_RING;
                    end
                end else if (mode_ans && dtr_eff && CR_I) begin
                    next_state = thm_pkg::THM_DIALING;
                end else if (MODE_I == `THM_MODE_HOTLINE && (dtr_rise || (dtr_sync && CR_I))) begin
                    next_state = thm_pkg::THM_HOT_WAIT;
                    go_dial = 1'b1;
                end else if (MODE_I == `THM_MODE_CONT_HOT && dtr_sync) begin
                    next_state = thm_pkg::THM_HOT_WAIT;
                    go_dial = 1'b1;
                end
            end
            thm_pkg::THM_RING: begin
                if (DM_CLEAR_I) begin
                    next_state = thm_pkg::THM_IDLE;
                end else if (dtr_eff) begin
                    next_state = thm_pkg::THM_CONNECTED;
                    go_answer = 1'b1;
                end
            end
            thm_pkg::THM_DIALING: begin
                if (DM_ANSWERED_I) begin
                    next_state = thm_pkg::THM_CONNECTED;
                end else if (DM_FAIL_I || brk_clear || dtr_fall_clear) begin
                    next_state = thm_pkg::THM_IDLE;
                end
            end
            thm_pkg::THM_HOT_WAIT: begin
                if (DM_ANSWERED_I) begin
                    next_state = thm_pkg::THM_CONNECTED;
                end else if (DM_FAIL_I) begin
                    // Mode 13 waits for a fresh rise or CR from idle
                    next_state = (MODE_I == `THM_MODE_CONT_HOT) ? thm_pkg::THM_HOT_RETRY
                        : thm_pkg::THM_IDLE;
                end
            end
            thm_pkg::THM_HOT_RETRY: begin
                if (!dtr_sync) begin
                    next_state = thm_pkg::THM_IDLE;
                end else if (tick && ms_cnt == `THM_RETRY_MS - 16'h0001) begin
                    next_state = thm_pkg::THM_HOT_WAIT;
                    go_dial = 1'b1;
                end
            end
            thm_pkg::THM_CONNECTED: begin
                if (DM_CLEAR_I) begin
                    next_state = thm_pkg::THM_DROP;
                end else if (brk_clear || dtr_fall_clear) begin
                    next_state = thm_pkg::THM_DROP;
                    go_term_clear = 1'b1;
                end
            end
            thm_pkg::THM_DROP: begin
                if (tick && ms_cnt == `THM_DROP_MS - 16'h0001) begin
                    next_state = thm_pkg::THM_IDLE;
                end
            end
            default: begin
                next_state = thm_pkg::THM_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            state <= thm_pkg::THM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // One millisecond timer, restarted on every state change
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I || next_state != state || ring_wrap) begin
            ms_cnt <= 16'h0000;
        end else if (tick) begin
            ms_cnt <= ms_cnt + 16'h0001;
        end
    end

    // DSR, DCD and CTS fall only during the clear-down interval; RI follows the ring cadence
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            DSR_O <= 1'b1;
            DCD_O <= 1'b1;
            CTS_O <= 1'b1;
            RI_O <= 1'b0;
        end else begin
            DSR_O <= next_state != thm_pkg::THM_DROP;
            DCD_O <= next_state != thm_pkg::THM_DROP;
            CTS_O <= next_state != thm_pkg::THM_DROP;
            RI_O <= next_state == thm_pkg::THM_RING && state == thm_pkg::THM_RING
                ? ms_cnt < `THM_RING_ON_MS : next_state == thm_pkg::THM_RING;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            ANSWER_O <= 1'b0;
            HOTLINE_DIAL_O <= 1'b0;
            TERM_CLEAR_O <= 1'b0;
            CONNECTED_O <= 1'b0;
            AUTOBAUD_O <= 1'b0;
        end else begin
            ANSWER_O <= go_answer;
            HOTLINE_DIAL_O <= go_dial;
            TERM_CLEAR_O <= go_term_clear;
            CONNECTED_O <= next_state == thm_pkg::THM_CONNECTED;
            AUTOBAUD_O <= next_state == thm_pkg::THM_IDLE && mode_ans && dtr_eff;
        end
    end

    // Echo only while the outgoing call is being set up
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            ECHO_VALID_O <= 1'b0;
            ECHO_CHAR_O <= 8'h00;
        end else begin
            ECHO_VALID_O <= CMD_VALID_I && state == thm_pkg::THM_DIALING;
            if (CMD_VALID_I && state == thm_pkg::THM_DIALING) begin
                ECHO_CHAR_O <= CMD_CHAR_I;
            end
        end
    end
endmodule : thm_top
`default_nettype wire

// [verification/thm_term_model.sv]
// Terminal model: raises DTR on seeing ring when allowed to answer
`timescale 1ns/1ps
`default_nettype none
module thm_term_model (
    input wire logic clk_i,
    input wire logic ri_i,
    input wire logic answer_en_i,
    input wire logic dtr_req_i,
    output logic dtr_o
);
    logic hold = 1'b0;
    // Answer is held until the bench withdraws consent, so a late enable answers slowly
    always @(posedge clk_i) begin
        hold <= answer_en_i & (hold | ri_i);
    end
    assign dtr_o = dtr_req_i | hold;
endmodule : thm_term_model
`default_nettype wire

// [verification/thm_top_checker.sv]
// Port assertions for the terminal handshake top
`timescale 1ns/1ps
`default_nettype none
module thm_top_checker (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic CMD_VALID_I,
    input wire logic [7:0] CMD_CHAR_I,
    input wire logic DSR_O,
    input wire logic DCD_O,
    input wire logic CTS_O,
    input wire logic RI_O,
    input wire logic AUTOBAUD_O,
    input wire logic ECHO_VALID_O,
    input wire logic [7:0] ECHO_CHAR_O,
    input wire logic ANSWER_O,
    input wire logic HOTLINE_DIAL_O,
    input wire logic TERM_CLEAR_O,
    input wire logic CONNECTED_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_leads_move_together: assert property (DSR_O == DCD_O && DCD_O == CTS_O)
        else $error("leads differ");
    a_reset_idle: assert property ($rose(RST_N_I) |-> DSR_O && !CONNECTED_O && !RI_O)
        else $error("not idle after reset");
    a_echo_char_match: assert property (ECHO_VALID_O |->
        $past(CMD_VALID_I) && ECHO_CHAR_O == $past(CMD_CHAR_I))
        else $error("bad echo");
    a_answer_connects: assert property (ANSWER_O |-> CONNECTED_O && !RI_O)
        else $error("answer without connect");
    a_ring_idle_only: assert property (RI_O |-> !CONNECTED_O && DSR_O)
        else $error("ring outside idle");
    a_clear_drops_leads: assert property (TERM_CLEAR_O && $past(CONNECTED_O)
        |-> ##[0:1] !DSR_O)
        else $error("clear kept leads");
    a_drop_holds_low: assert property ($fell(DSR_O) |-> !DSR_O [*8])
        else $error("drop too short");
    a_autobaud_idle: assert property (AUTOBAUD_O |-> DSR_O && !CONNECTED_O)
        else $error("autobaud while busy");
    a_dial_not_conn: assert property (HOTLINE_DIAL_O |-> !CONNECTED_O && !AUTOBAUD_O)
        else $error("dial while busy");
endmodule : thm_top_checker
bind thm_top thm_top_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
    .CMD_VALID_I(CMD_VALID_I), .CMD_CHAR_I(CMD_CHAR_I), .DSR_O(DSR_O), .DCD_O(DCD_O),
    .CTS_O(CTS_O), .RI_O(RI_O), .AUTOBAUD_O(AUTOBAUD_O), .ECHO_VALID_O(ECHO_VALID_O),
    .ECHO_CHAR_O(ECHO_CHAR_O), .ANSWER_O(ANSWER_O), .HOTLINE_DIAL_O(HOTLINE_DIAL_O),
    .TERM_CLEAR_O(TERM_CLEAR_O), .CONNECTED_O(CONNECTED_O));
`default_nettype wire

// [verification/test_thm_top.sv]
// Self-checking bench for the terminal handshake top
`timescale 1ns/1ps
`default_nettype none
module test_thm_top;
    logic clk = 1'b0, rst_n = 1'b0, ans_en = 1'b0, dtr_req = 1'b0, dtr;
    logic [3:0] mode = 4'hC;
    logic [7:0] pv = 8'h00;
    logic [7:0] ch = 8'h00, lf = 8'h22;
    logic dsr, dcd, cts, ri, ab, ev, an, hd, tc, cn;
    logic [7:0] ec;
    int mismatches = 0, cmp_count = 0, n_ans = 0, n_dial = 0, n_clr = 0, n_echo = 0;
    // One tick per cycle, so one ms is one cycle and the 40 s retry fits the run
    thm_top #(.CYC_PER_TICK(1)) u_thm_top (.CORE_CLK_I(clk), .RST_N_I(rst_n),
        .MODE_I(mode), .DTR_I(dtr), .CR_I(pv[0]), .BREAK_LONG_I(pv[1]),
        .BREAK_SHORT_I(pv[2]), .CMD_VALID_I(pv[3]), .CMD_CHAR_I(ch),
        .DM_CALL_IN_I(pv[4]), .DM_CLEAR_I(pv[5]), .DM_ANSWERED_I(pv[6]),
        .DM_FAIL_I(pv[7]), .DSR_O(dsr), .DCD_O(dcd), .CTS_O(cts), .RI_O(ri),
        .AUTOBAUD_O(ab), .ECHO_VALID_O(ev), .ECHO_CHAR_O(ec), .ANSWER_O(an),
        .HOTLINE_DIAL_O(hd), .TERM_CLEAR_O(tc), .CONNECTED_O(cn));
    thm_term_model u_thm_term_model (.clk_i(clk), .ri_i(ri), .answer_en_i(ans_en),
        .dtr_req_i(dtr_req), .dtr_o(dtr));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        n_ans += (an === 1'b1);
        n_dial += (hd === 1'b1);
        n_clr += (tc === 1'b1);
        if (ev === 1'b1) begin
            n_echo++;
            chk(ec === ch, "echo char");
        end
    end
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nxt
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(input int b);
        pv[b] = 1'b1;
        tick(1);
        pv[b] = 1'b0;
    endtask : pulse
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    initial begin
        #(100000 * 40);
        mismatches++;
        finish_test();
    end
    initial begin
        tick(6);
        rst_n = 1'b1;
        tick(3);
        chk(dsr & dcd & cts & !cn, "idle leads");
        pulse(4);
        chk(ri, "ring on");
        tick(1990);
        chk(ri, "ring held");
        tick(20);
        chk(!ri, "ring off");
        ans_en = 1'b1;
        tick(4020);
        chk(n_ans == 1 && cn && !ri, "answer on ring");
        pulse(5);
        tick(2);
        chk(!dsr && n_clr == 0, "far clear drop");
        tick(196);
        chk(!dsr, "far clear hold");
        tick(4);
        chk(dsr, "far clear restore");
        ans_en = 1'b0;
        dtr_req = 1'b1;
        tick(5);
        chk(ab, "autobaud wait");
        pulse(4);
        tick(1);
        chk(n_ans == 2 && cn && !ri, "immediate answer");
        tick(600);
        dtr_req = 1'b0;
        tick(6);
        chk(n_clr == 1 && !dsr, "dtr fall clear");
        tick(210);
        dtr_req = 1'b1;
        tick(5);
        pulse(0);
        chk(!ab, "autobaud done");
        for (int i = 0; i < 6; i++) begin
            lf = nxt(lf);
            ch = lf;
            pulse(3);
            tick(1);
        end
        chk(n_echo == 6, "echo count");
        pulse(6);
        for (int i = 0; i < 3; i++) begin
            tick(1);
            chk(cn === 1'b1, "break count");
            pulse(2);
        end
        tick(1);
        chk(!dsr && n_clr == 2, "three breaks");
        dtr_req = 1'b0;
        tick(210);
        mode = 4'hD;
        tick(4);
        dtr_req = 1'b1;
        tick(5);
        chk(n_dial == 1, "hotline dial");
        pulse(7);
        tick(4);
        chk(n_dial == 1, "no redial");
        dtr_req = 1'b0;
        tick(4);
        dtr_req = 1'b1;
        tick(5);
        chk(n_dial == 2, "rise redial");
        pulse(7);
        tick(4);
        pulse(0);
        tick(1);
        chk(n_dial == 3, "cr redial");
        pulse(6);
        tick(1);
        pulse(1);
        tick(1);
        chk(!dsr && n_clr == 3, "hotline clear");
        dtr_req = 1'b0;
        tick(210);
        mode = 4'hE;
        tick(4);
        pulse(4);
        tick(1);
        chk(n_ans == 3 && cn, "forced dtr answer");
        dtr_req = 1'b1;
        tick(150);
        dtr_req = 1'b0;
        tick(6);
        chk(cn && dsr, "dtr drop ignored");
        pulse(1);
        tick(1);
        chk(!dsr && n_clr == 4, "break clear");
        tick(210);
        mode = 4'hF;
        tick(4);
        dtr_req = 1'b1;
        tick(5);
        chk(n_dial == 4, "level dial");
        pulse(7);
        tick(39990);
        chk(n_dial == 4, "retry wait");
        tick(20);
        chk(n_dial == 5, "retry 40 s");
        finish_test();
    end
endmodule : test_thm_top
`default_nettype wire
